// ---- common/eac_params.svh ----
`ifndef EAC_PARAMS_SVH
`define EAC_PARAMS_SVH

// ----------------------------------------
// Register selects on the I/O port
// ----------------------------------------
`define EAC_SEL_ADDR_LOW 2'h0
`define EAC_SEL_ADDR_HIGH 2'h1
`define EAC_SEL_DATA 2'h2
`define EAC_SEL_CTRL 2'h3

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define EAC_BIT_READ 0
`define EAC_BIT_PROG 1
`define EAC_BIT_MASTER 2
`define EAC_BIT_RIE 3
`define EAC_MODE_LSB 4
`define EAC_MODE_MSB 5
`define EAC_ADDR_HIGH_BITS 4

// ----------------------------------------
// Array geometry and reset values
// ----------------------------------------
`define EAC_INDEX_W 10
`define EAC_DEPTH 1024
`define EAC_ERASED_BYTE 8'hFF
`define EAC_MODE_RESET 2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define EAC_MASTER_WINDOW 3'h4
`define EAC_STALL_READ 3'h4
`define EAC_STALL_PROG 3'h2
`define EAC_T_ATOMIC_US 3400
`define EAC_T_PHASE_US 1800
`define EAC_T_WRITE_US 3300
`define EAC_RC_TICKS_WRITE 26368
`define EAC_RC_TICKS_PHASE \
    (((`EAC_RC_TICKS_WRITE * `EAC_T_PHASE_US) + `EAC_T_WRITE_US - 1) / `EAC_T_WRITE_US)
`define EAC_PCNT_W 15

`endif

// ---- common/eac_pkg.sv ----
package eac_pkg;

    typedef enum logic [1:0]
    {
        EAC_MODE_ATOMIC = 2'h0,
        EAC_MODE_ERASE = 2'h1,
        EAC_MODE_WRITE = 2'h2,
        EAC_MODE_RSVD = 2'h3
    } eac_mode_t;

    // Gray along idle -> program -> commit; commit -> idle flips both bits
    typedef enum logic [1:0]
    {
        EAC_ST_IDLE = 2'h0,
        EAC_ST_PROG = 2'h1,
        EAC_ST_COMMIT = 2'h3
    } eac_state_t;

endpackage

// ---- rtl/eac_top.sv ----
`timescale 1ns/100ps
`include "eac_params.svh"
// Contract
// - Mode 00 erase+write, 01 erase only, 10 write only, 11 reserved.
// - Writes to the mode field are ignored while programming is busy.
// - Reset clears mode field to 00 unless programming is in progress.
// - Ready interrupt asserted while enabled, global enable set and not busy.
// - Strobe starts programming only within four cycles of master enable.
// - Master enable self-clears four cycles after software sets it.
// - Strobe bit reads one while programming, hardware clears it at end.
// - Launching programming stalls the CPU for two cycles.
// - Read strobe fetches byte at once and stalls CPU four cycles.
// - While busy, reads are blocked and address writes ignored.
// - Erase+write timed by 26,368 calibrated RC oscillator cycles, about 3.3 ms.
// - Address high bits 7:4 and control top bits read zero; address high bits 3:2 read back as written.
// - Bytes addressed linearly from zero to top of the array.
// - Data register supplies write byte and holds fetched read byte.
// - Access timing comes from the RC oscillator, not the CPU clock.
// - A running programming operation completes despite a system reset.
module eac_top
    import eac_pkg::*;
#(
    parameter int unsigned ATOMIC_TICKS = `EAC_RC_TICKS_WRITE,
    parameter int unsigned PHASE_TICKS = `EAC_RC_TICKS_PHASE
)
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic pwr_rstn_in,
    input wire logic rc_tick_in,
    input wire logic global_irq_enable_in,
    input wire logic [1:0] io_sel_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    output logic cpu_stall_out,
    output logic ready_irq_out
);

    // ----------------------------------------
    // Reset synchronisers
    // ----------------------------------------
    logic rst_meta;
    logic rst_n;
    logic por_meta;
    logic por_n;

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Power-on reset alone clears the programming engine
    always_ff @(posedge ref_clk_in or negedge pwr_rstn_in)
    begin
        if (!pwr_rstn_in)
        begin
            por_meta <= 1'b0;
            por_n <= 1'b0;
        end
        else
        begin
            por_meta <= 1'b1;
            por_n <= por_meta;
        end
    end

    // ----------------------------------------
    // Register state and decode
    // ----------------------------------------
    logic [7:0] mem [`EAC_DEPTH];
    logic [7:0] eeprom_address_low;
    logic [`EAC_ADDR_HIGH_BITS-1:0] eeprom_address_high;
    logic [7:0] eeprom_data_byte;
    eac_mode_t prog_mode;
    logic ready_irq_enable;
    logic [2:0] master_cnt;
    logic [2:0] stall_cnt;
    logic [2:0] next_stall;
    eac_state_t state;
    logic [`EAC_PCNT_W-1:0] prog_cnt;
    eac_mode_t op_mode;
    logic [`EAC_INDEX_W-1:0] op_index;
    logic [7:0] op_data;
    logic [7:0] next_rdata;

    wire [`EAC_INDEX_W-1:0] byte_index =
        {eeprom_address_high[1:0], eeprom_address_low};
    wire [7:0] array_byte = mem[byte_index];
    wire busy = (state != EAC_ST_IDLE);
    wire master_write_enable = (master_cnt != 3'h0);
    wire ctrl_wr = io_wr_in && (io_sel_in == `EAC_SEL_CTRL);
    wire [1:0] wr_mode = io_wdata_in[`EAC_MODE_MSB:`EAC_MODE_LSB];
    wire launch = ctrl_wr && io_wdata_in[`EAC_BIT_PROG]
        && master_write_enable && !busy;
    wire read_go = ctrl_wr && io_wdata_in[`EAC_BIT_READ] && !busy;
    wire master_load = ctrl_wr && io_wdata_in[`EAC_BIT_MASTER]
        && !master_write_enable && !launch;

    // ----------------------------------------
    // Address and data registers
    // ----------------------------------------
    // Address is kept across system reset so an in-flight write is unaffected
    always_ff @(posedge ref_clk_in or negedge por_n)
    begin
        if (!por_n)
        begin
            eeprom_address_low <= 8'h00;
            eeprom_address_high <= 4'h0;
        end
        else if (io_wr_in && !busy)
        begin
            if (io_sel_in == `EAC_SEL_ADDR_LOW)
            begin
                eeprom_address_low <= io_wdata_in;
            end
            else if (io_sel_in == `EAC_SEL_ADDR_HIGH)
            begin
                eeprom_address_high <= io_wdata_in[`EAC_ADDR_HIGH_BITS-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            eeprom_data_byte <= 8'h00;
        end
        else if (read_go)
        begin
            eeprom_data_byte <= array_byte;
        end
        else if (io_wr_in && (io_sel_in == `EAC_SEL_DATA))
        begin
            eeprom_data_byte <= io_wdata_in;
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready_irq_enable <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            ready_irq_enable <= io_wdata_in[`EAC_BIT_RIE];
        end
    end

    // Re-arming inside the window does not extend it; a launch consumes it
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            master_cnt <= 3'h0;
        end
        else if (launch)
        begin
            master_cnt <= 3'h0;
        end
        else if (master_load)
        begin
            master_cnt <= `EAC_MASTER_WINDOW;
        end
        else if (master_write_enable)
        begin
            master_cnt <= master_cnt - 3'h1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge por_n)
    begin
        if (!por_n)
        begin
            prog_mode <= EAC_MODE_ATOMIC;
        end
        else if (!rst_n && !busy)
        begin
            prog_mode <= eac_mode_t'(`EAC_MODE_RESET);
        end
        else if (rst_n && ctrl_wr && !busy)
        begin
            prog_mode <= eac_mode_t'(wr_mode);
        end
    end

    // ----------------------------------------
    // Programming engine
    // ----------------------------------------
    // Runs on power-on reset only so a system reset cannot cut a write short
    always_ff @(posedge ref_clk_in or negedge por_n)
    begin
        if (!por_n)
        begin
            state <= EAC_ST_IDLE;
            prog_cnt <= '0;
            op_mode <= EAC_MODE_ATOMIC;
            op_index <= '0;
            op_data <= 8'h00;
        end
        else
        begin
            case (state)
                EAC_ST_IDLE:
                begin
                    if (launch && rst_n)
                    begin
                        op_mode <= eac_mode_t'(wr_mode);
                        op_index <= byte_index;
                        op_data <= eeprom_data_byte;
                        if (eac_mode_t'(wr_mode) == EAC_MODE_RSVD)
                        begin
                            state <= EAC_ST_COMMIT;
                        end
                        else
                        begin
                            state <= EAC_ST_PROG;
                            if (eac_mode_t'(wr_mode) == EAC_MODE_ATOMIC)
                            begin
                                prog_cnt <= ATOMIC_TICKS[`EAC_PCNT_W-1:0];
                            end
                            else
                            begin
                                prog_cnt <= PHASE_TICKS[`EAC_PCNT_W-1:0];
                            end
                        end
                    end
                end
                EAC_ST_PROG:
                begin
                    if (rc_tick_in)
                    begin
                        prog_cnt <= prog_cnt - 1'b1;
                        if (prog_cnt == `EAC_PCNT_W'(1))
                        begin
                            state <= EAC_ST_COMMIT;
                        end
                    end
                end
                EAC_ST_COMMIT:
                begin
                    state <= EAC_ST_IDLE;
                end
                default:
                begin
                    state <= EAC_ST_IDLE;
                end
            endcase
        end
    end

    // Array cells; an atomic cycle ends with the new byte, write-only can only clear bits
    always_ff @(posedge ref_clk_in)
    begin
        if (state == EAC_ST_COMMIT)
        begin
            case (op_mode)
                EAC_MODE_ATOMIC: mem[op_index] <= op_data;
                EAC_MODE_ERASE: mem[op_index] <= `EAC_ERASED_BYTE;
                EAC_MODE_WRITE: mem[op_index] <= mem[op_index] & op_data;
                default: mem[op_index] <= mem[op_index];
            endcase
        end
    end

    // ----------------------------------------
    // CPU stall, interrupt and read-back
    // ----------------------------------------
    always_comb
    begin
        if (read_go)
        begin
            next_stall = `EAC_STALL_READ;
        end
        else if (launch)
        begin
            next_stall = `EAC_STALL_PROG;
        end
        else if (stall_cnt != 3'h0)
        begin
            next_stall = stall_cnt - 3'h1;
        end
        else
        begin
            next_stall = 3'h0;
        end
    end

    always_comb
    begin
        case (io_sel_in)
            `EAC_SEL_ADDR_LOW: next_rdata = eeprom_address_low;
            `EAC_SEL_ADDR_HIGH: next_rdata = {4'h0, eeprom_address_high};
            `EAC_SEL_DATA: next_rdata = eeprom_data_byte;
            `EAC_SEL_CTRL: next_rdata = {2'h0, prog_mode, ready_irq_enable,
                master_write_enable, busy, 1'b0};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stall_cnt <= 3'h0;
            cpu_stall_out <= 1'b0;
            ready_irq_out <= 1'b0;
            io_rdata_out <= 8'h00;
        end
        else
        begin
            stall_cnt <= next_stall;
            cpu_stall_out <= (next_stall != 3'h0);
            ready_irq_out <= ready_irq_enable && global_irq_enable_in && !busy;
            if (io_rd_in)
            begin
                io_rdata_out <= next_rdata;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!por_n);

    property p_mode_hold;
        (busy && ctrl_wr) |=> (prog_mode == $past(prog_mode));
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed while busy");

    property p_mode_reset;
        (!rst_n && !busy) |=> (prog_mode == EAC_MODE_ATOMIC);
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("mode not cleared by reset");

    property p_ready_irq;
        (rst_n && ready_irq_enable && global_irq_enable_in && !busy) [*2] |=> ready_irq_out;
    endproperty
    a_ready_irq: assert property (p_ready_irq) else $error("ready interrupt missing");

    property p_strobe_no_master;
        (rst_n && ctrl_wr && io_wdata_in[`EAC_BIT_PROG] && !master_write_enable && !busy)
            |=> !busy;
    endproperty
    a_strobe_no_master: assert property (p_strobe_no_master)
        else $error("strobe without master enable started programming");

    property p_launch_busy;
        (rst_n && launch && (eac_mode_t'(wr_mode) != EAC_MODE_RSVD))
            |=> busy ##1 busy;
    endproperty
    a_launch_busy: assert property (p_launch_busy) else $error("launch did not set busy");

    property p_busy_readback;
        (rst_n && busy && io_rd_in && (io_sel_in == `EAC_SEL_CTRL))
            |=> io_rdata_out[`EAC_BIT_PROG];
    endproperty
    a_busy_readback: assert property (p_busy_readback)
        else $error("strobe bit read zero while programming");

    property p_master_timeout;
        (rst_n && master_load) |=> master_write_enable ##4 !master_write_enable;
    endproperty
    a_master_timeout: assert property (p_master_timeout)
        else $error("master enable window wrong length");

    property p_stall_prog;
        (rst_n && launch) |=> cpu_stall_out [*2] ##1 !cpu_stall_out;
    endproperty
    a_stall_prog: assert property (p_stall_prog) else $error("program stall not two cycles");

    property p_stall_read;
        (rst_n && read_go) |=> cpu_stall_out [*4] ##1 !cpu_stall_out;
    endproperty
    a_stall_read: assert property (p_stall_read) else $error("read stall not four cycles");

    property p_read_data;
        (rst_n && read_go) |=> (eeprom_data_byte == $past(array_byte));
    endproperty
    a_read_data: assert property (p_read_data) else $error("read byte not fetched");

    property p_addr_hold;
        (busy && io_wr_in) |=> (byte_index == $past(byte_index));
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address changed while busy");

    property p_rsvd_quick;
        (rst_n && launch && (eac_mode_t'(wr_mode) == EAC_MODE_RSVD)) |=> busy ##1 !busy;
    endproperty
    a_rsvd_quick: assert property (p_rsvd_quick) else $error("reserved mode stayed busy");

    property p_reserved_bits;
        (rst_n && io_rd_in && (io_sel_in == `EAC_SEL_ADDR_HIGH)) |=> (io_rdata_out[7:4] == 4'h0);
    endproperty
    a_reserved_bits: assert property (p_reserved_bits) else $error("reserved bits nonzero");

    property p_commit_on_tick;
        (state == EAC_ST_COMMIT && op_mode != EAC_MODE_RSVD) |-> $past(rc_tick_in);
    endproperty
    a_commit_on_tick: assert property (p_commit_on_tick)
        else $error("programming ended without oscillator tick");

    c_atomic: cover property (launch && eac_mode_t'(wr_mode) == EAC_MODE_ATOMIC);
    c_read: cover property (read_go ##1 cpu_stall_out);
    c_rsvd: cover property (launch && eac_mode_t'(wr_mode) == EAC_MODE_RSVD);
    c_reset_busy: cover property (busy && !rst_n);

endmodule

// ---- tb/eac_cpu_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// CPU side of the I/O port
// ----------------------------------------
module eac_cpu_model (
    input wire logic clk_in,
    input wire logic stall_in,
    input wire logic [7:0] rdata_in,
    output logic [1:0] sel_out,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] wdata_out
);
    initial
    begin
        sel_out = 2'h0;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end

    // Core issues nothing while held; n reports how long it was held
    task automatic wait_stall(output int n);
        n = 0;
        while (stall_in === 1'b1 && n < 16)
        begin
            n++;
            @(negedge clk_in);
        end
    endtask

    task automatic io_write(input logic [1:0] sel, input logic [7:0] data, output int n);
        @(negedge clk_in);
        sel_out = sel;
        wdata_out = data;
        wr_out = 1'b1;
        @(posedge clk_in);
        @(negedge clk_in);
        wr_out = 1'b0;
        // Scramble the idle bus so stale data cannot pass
        wdata_out = ~data;
        wait_stall(n);
    endtask

    task automatic io_read(input logic [1:0] sel, output logic [7:0] data);
        @(negedge clk_in);
        sel_out = sel;
        rd_out = 1'b1;
        @(posedge clk_in);
        @(negedge clk_in);
        rd_out = 1'b0;
        @(negedge clk_in);
        data = rdata_in;
    endtask
endmodule

// ---- tb/eeprom_access_controller_tb.sv ----
`timescale 1ns/100ps
`include "eac_params.svh"
module eeprom_access_controller_tb
    import eac_pkg::*;
;
    localparam int unsigned ATOMIC = 5;
    localparam int unsigned PHASE = 3;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic pwr_rstn = 1'b0;
    logic rc_tick = 1'b0;
    logic gie = 1'b0;
    logic rie = 1'b0;
    logic [1:0] sel;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic stall;
    logic irq;
    logic [7:0] shadow [0:1023];
    logic [7:0] d;
    logic [9:0] a;
    int n;
    int bad_count = 0;
    int n_compared = 0;
    int rc_div = 0;
    int ticks = 0;
    logic tick_en = 1'b0;

    always #10 clk = ~clk;

    // ----------------------------------------
    // Slow oscillator ticks, one every ten bus clock cycles
    // ----------------------------------------
    always @(negedge clk)
    begin
        rc_div <= (rc_div + 1) % 10;
        rc_tick <= (rc_div == 9);
    end

    always @(posedge clk)
    begin
        // Only ticks the engine can see; polling lag must not add or lose any
        if (tick_en && rc_tick === 1'b1 && i_dut.busy === 1'b1)
            ticks <= ticks + 1;
    end

    eac_top #(.ATOMIC_TICKS(ATOMIC), .PHASE_TICKS(PHASE)) i_dut (
        .ref_clk_in(clk), .rstn_in(rstn), .pwr_rstn_in(pwr_rstn), .rc_tick_in(rc_tick),
        .global_irq_enable_in(gie), .io_sel_in(sel), .io_wr_in(wr), .io_rd_in(rd),
        .io_wdata_in(wdata), .io_rdata_out(rdata), .cpu_stall_out(stall),
        .ready_irq_out(irq));

    eac_cpu_model i_cpu (.clk_in(clk), .stall_in(stall), .rdata_in(rdata), .sel_out(sel),
        .wr_out(wr), .rd_out(rd), .wdata_out(wdata));

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic logic [7:0] after_prog(eac_mode_t m, logic [7:0] old, logic [7:0] v);
        case (m)
            EAC_MODE_ATOMIC: return v;
            EAC_MODE_ERASE: return 8'hFF;
            EAC_MODE_WRITE: return old & v;
            default: return old;
        endcase
    endfunction

    // ----------------------------------------
    // Software sequences
    // ----------------------------------------
    task automatic set_addr(input logic [9:0] ad);
        int s;
        i_cpu.io_write(`EAC_SEL_ADDR_LOW, ad[7:0], s);
        i_cpu.io_write(`EAC_SEL_ADDR_HIGH, {6'h00, ad[9:8]}, s);
    endtask

    // No flash self-programming exists in this bench, so that wait is empty
    task automatic launch(input logic [9:0] ad, input logic [7:0] v, input logic [1:0] m);
        logic g;
        int s;
        g = gie;
        gie = 1'b0;
        set_addr(ad);
        i_cpu.io_write(`EAC_SEL_DATA, v, s);
        i_cpu.io_write(`EAC_SEL_CTRL, {2'h0, m, rie, 3'h4}, s);
        ticks = 0;
        tick_en = 1'b1;
        i_cpu.io_write(`EAC_SEL_CTRL, {2'h0, m, rie, 3'h2}, s);
        check("prog stall", 8'(s), 8'h02);
        gie = g;
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        d = 8'h02;
        while (d[1] !== 1'b0)
        begin
            i_cpu.io_read(`EAC_SEL_CTRL, d);
            k++;
            if (k > 200)
            begin
                bad_count++;
                print_verdict();
            end
        end
        tick_en = 1'b0;
    endtask

    task automatic ee_read(input logic [9:0] ad, output logic [7:0] v);
        int s;
        set_addr(ad);
        i_cpu.io_write(`EAC_SEL_CTRL, 8'h01, s);
        check("read stall", 8'(s), 8'h04);
        i_cpu.io_read(`EAC_SEL_DATA, v);
    endtask

    task automatic prog_check(input logic [9:0] ad, input logic [7:0] v, input eac_mode_t m);
        logic [7:0] got;
        shadow[ad] = after_prog(m, shadow[ad], v);
        launch(ad, v, m);
        wait_idle();
        if (m != EAC_MODE_RSVD)
            check("rc ticks", 8'(ticks), 8'((m == EAC_MODE_ATOMIC) ? ATOMIC : PHASE));
        ee_read(ad, got);
        check("array byte", got, shadow[ad]);
    endtask

    task automatic pulse_rst();
        @(negedge clk);
        rstn = 1'b0;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        bad_count++;
        print_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(37));
        repeat (4) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        pwr_rstn = 1'b1;
        repeat (3) @(negedge clk);
        i_cpu.io_read(`EAC_SEL_CTRL, d);
        check("ctrl reset", d, 8'h00);
        i_cpu.io_write(`EAC_SEL_ADDR_HIGH, 8'hFF, n);
        i_cpu.io_read(`EAC_SEL_ADDR_HIGH, d);
        check("addr high spare", d, 8'h0F);
        i_cpu.io_write(`EAC_SEL_CTRL, 8'hD0, n);
        i_cpu.io_read(`EAC_SEL_CTRL, d);
        check("ctrl spare", d, 8'h10);
        pulse_rst();
        i_cpu.io_read(`EAC_SEL_CTRL, d);
        check("mode after reset", d, 8'h00);
        i_cpu.io_write(`EAC_SEL_CTRL, 8'h04, n);
        i_cpu.io_read(`EAC_SEL_CTRL, d);
        check("master open", d & 8'h04, 8'h04);
        repeat (4) @(negedge clk);
        i_cpu.io_read(`EAC_SEL_CTRL, d);
        check("master closed", d & 8'h04, 8'h00);
        i_cpu.io_write(`EAC_SEL_CTRL, 8'h02, n);
        check("late strobe stall", 8'(n), 8'h00);
        i_cpu.io_read(`EAC_SEL_CTRL, d);
        check("late strobe busy", d & 8'h02, 8'h00);
        prog_check(10'h000, 8'($urandom), EAC_MODE_ATOMIC);
        prog_check(10'h3FF, 8'($urandom), EAC_MODE_ATOMIC);
        for (int m = 1; m < 4; m++)
            prog_check(10'h3FF, 8'($urandom), eac_mode_t'(m));
        for (int i = 0; i < 8; i++)
        begin
            a = 10'($urandom_range(1023));
            prog_check(a, 8'($urandom), EAC_MODE_ATOMIC);
            prog_check(a, 8'($urandom), eac_mode_t'($urandom_range(3)));
        end
        // Busy window: mode, address and reads all locked out
        rie = 1'b1;
        gie = 1'b1;
        shadow[10'h155] = 8'h5A;
        launch(10'h155, 8'h5A, 2'h0);
        @(negedge clk);
        check("irq while busy", 8'(irq), 8'h00);
        i_cpu.io_write(`EAC_SEL_CTRL, 8'h38, n);
        i_cpu.io_read(`EAC_SEL_CTRL, d);
        check("mode locked", d & 8'h32, 8'h02);
        i_cpu.io_write(`EAC_SEL_ADDR_LOW, 8'hAA, n);
        i_cpu.io_write(`EAC_SEL_CTRL, 8'h09, n);
        check("blocked read stall", 8'(n), 8'h00);
        wait_idle();
        repeat (2) @(negedge clk);
        check("irq when ready", 8'(irq), 8'h01);
        gie = 1'b0;
        repeat (2) @(negedge clk);
        check("irq masked", 8'(irq), 8'h00);
        i_cpu.io_read(`EAC_SEL_ADDR_LOW, d);
        check("addr locked", d, 8'h55);
        ee_read(10'h155, d);
        check("busy op byte", d, 8'h5A);
        rie = 1'b0;
        // System reset in mid-programming must not abort it
        shadow[10'h3FF] = shadow[10'h3FF] & 8'hC3;
        launch(10'h3FF, 8'hC3, 2'h2);
        pulse_rst();
        i_cpu.io_read(`EAC_SEL_CTRL, d);
        check("busy through reset", d & 8'h32, 8'h22);
        wait_idle();
        ee_read(10'h3FF, d);
        check("op after reset", d, shadow[10'h3FF]);
        print_verdict();
    end
endmodule
